// file: hdl/aodr_ctrl.v
// Audio output control: byte registers, rate matcher, volume, dither selection and modulators.
// Assumes one 40 MHz clock, synchronous samples from the fetch side, an AXI4-Lite master.
//
// Behaviour
// (R1) Left constant-select set: left dither is the 16-bit left constant.
// (R2) Right constant-select set: right dither is the 16-bit right constant.
// (R3) Left plain noise: constant and shaping off, one generator enabled.
// (R4) Left shaped noise: constant off, shaping on, one generator enabled.
// (R5) Right plain noise: constant and shaping off, one generator enabled.
// (R6) Right shaped noise: constant off, shaping on, one generator enabled.
// (R7) Left noise generators: bit 6 enables the first, bit 5 the second.
// (R8) Right noise generators: bit 6 enables the first, bit 5 the second.
// (R9) Left 5-bit size fields give 0 to 16 bits per generator.
// (R10) Right 5-bit size fields give 0 to 16 bits per generator.
// (R11) Step is high byte, middle byte and factor byte upper nibble.
// (R12) An 8-bit register, reset 0x01, fine-tunes the step.
// (R13) Factor byte low nibble divides down the serial bit clock.
// (R14) Control bits 1 to 7 enable players, recorder, interface, center, highpass.
// (R15) Control bit 0 selects mono when 1, stereo when 0.
// (R16) PWM mode on mode bit 1; bit 0 suppresses doubling the sample.
// (R17) Mode bit 2 picks linear interpolation, else sample-hold.
// (R18) Mode bit 7 swaps the serial input left and right channels.
// (R19) Exchange bit swaps data between the two modulators.
// (R20) Constants: low byte at lower index, both reset to zero.
// (R21) Sample rate over modulator clock equals step divided by 0x80000.
// (R22) Only one dither source feeds each modulator at a time.
// (R23) Modulators take 16-bit samples and give a 1-bit stream.
// (R24) Volume register scales the output level.
// (R25) Software sets the step to the real clock before enabling players.
//
// Design decision made here: the AXI4-Lite register port.
`include "aodr_regs.vh"

module aodr_ctrl #(
	parameter [15:0] SEED_FIRST  = 16'hACE1,
	parameter [15:0] SEED_SECOND = 16'h5A3C
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire [15:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [15:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] sample_left,
	input  wire [15:0] sample_right,
	input  wire        sample_valid,
	output reg         sample_ready,
	output reg         sdm_out_left,
	output reg         sdm_out_right,
	output reg         serial_bit_clock,
	output reg  [7:0]  audio_enables,
	output reg  [7:0]  center_level,
	output reg  [19:0] rate_step,
	output reg  [7:0]  step_tune
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function [7:0] reg_reset;
		input [3:0] i;
		begin
			case (i)
				4'h0: reg_reset = `AODR_RST_CONTROL;
				4'h1: reg_reset = `AODR_RST_CENTER;
				4'h2: reg_reset = `AODR_RST_VOLUME;
				4'h3: reg_reset = `AODR_RST_MODE;
				4'h4: reg_reset = `AODR_RST_TUNE;
				4'h5: reg_reset = `AODR_RST_FACTOR;
				4'h6: reg_reset = `AODR_RST_STEP_MID;
				4'h7: reg_reset = `AODR_RST_STEP_HIGH;
				4'h8: reg_reset = `AODR_RST_NOISE_LA;
				4'h9: reg_reset = `AODR_RST_NOISE_LB;
				4'hA: reg_reset = `AODR_RST_NOISE_RA;
				4'hB: reg_reset = `AODR_RST_NOISE_RB;
				default: reg_reset = `AODR_RST_CONST;
			endcase
		end
	endfunction

	function [7:0] reg_mask;
		input [3:0] i;
		begin
			case (i)
				4'h3: reg_mask = `AODR_MASK_MODE;
				4'h8: reg_mask = `AODR_MASK_NOISE_A;
				4'h9: reg_mask = `AODR_MASK_NOISE_A;
				4'hA: reg_mask = `AODR_MASK_NOISE_RA;
				4'hB: reg_mask = `AODR_MASK_NOISE_RB;
				default: reg_mask = `AODR_MASK_ALL;
			endcase
		end
	endfunction

	// Constant beats noise; with no generator enabled the dither is zero.
	function [1:0] dither_src;
		input const_sel;
		input shape;
		input en_first;
		input en_second;
		begin
			if (const_sel)
				dither_src = `AODR_DSRC_CONST;
			else if (!(en_first | en_second))
				dither_src = `AODR_DSRC_NONE;
			else if (shape)
				dither_src = `AODR_DSRC_SHAPED;
			else
				dither_src = `AODR_DSRC_NOISE;
		end
	endfunction

	// Sizes above 16 are clamped, since the generators are 16 bits wide.
	function [16:0] noise_term;
		input [15:0] lfsr;
		input [4:0]  nbits;
		input        enable;
		reg   [4:0]  n;
		reg   [15:0] t;
		begin
			n = (nbits > `AODR_NOISE_MAX_BITS) ? `AODR_NOISE_MAX_BITS : nbits;
			t = $signed(lfsr) >>> (`AODR_NOISE_MAX_BITS - n);
			if (!enable || n == 5'd0)
				noise_term = 17'h00000;
			else
				noise_term = {t[15], t};
		end
	endfunction

	function [15:0] lfsr_next;
		input [15:0] s;
		begin
			lfsr_next = {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
		end
	endfunction

	function [15:0] sat16;
		input signed [47:0] v;
		begin
			if (v > 48'sd32767)
				sat16 = 16'h7FFF;
			else if (v < -48'sd32768)
				sat16 = 16'h8000;
			else
				sat16 = v[15:0];
		end
	endfunction

	// Unity gain at a shift of 16; half and quarter add fractions of the shifted value.
	function [15:0] vol_apply;
		input [15:0] x;
		input [7:0]  v;
		reg signed [47:0] p;
		begin
			p = $signed({{32{x[15]}}, x}) <<< v[6:2];
			p = p + (v[`AODR_VOL_HALF] ? (p >>> 1) : 48'sd0)
				+ (v[`AODR_VOL_QUARTER] ? (p >>> 2) : 48'sd0);
			vol_apply = v[`AODR_VOL_MUTE] ? 16'h0000 : sat16(p >>> 16);
		end
	endfunction

	function [15:0] interp;
		input [15:0] prev;
		input [15:0] cur;
		input [7:0]  frac;
		input        linear;
		reg signed [16:0] d;
		reg signed [25:0] p;
		reg signed [25:0] r;
		begin
			d = $signed({cur[15], cur}) - $signed({prev[15], prev});
			p = d * $signed({1'b0, frac});
			r = $signed({{10{prev[15]}}, prev}) + (p >>> 8);
			interp = linear ? r[15:0] : cur;
		end
	endfunction

	function [15:0] pwm_scale;
		input [15:0] x;
		input        pwm;
		input        no_double;
		begin
			if (pwm && !no_double)
				pwm_scale = sat16($signed({{32{x[15]}}, x}) <<< 1);
			else
				pwm_scale = x;
		end
	endfunction

	// ****************************************************************
	// Register file and AXI4-Lite slave
	// ****************************************************************
	reg  [7:0]  regs [0:15];
	reg  [15:0] aw_addr;
	reg         aw_held;
	reg  [7:0]  w_byte;
	reg         w_lane0;
	reg         w_held;
	reg  [7:0]  status;
	wire        aw_regs   = aw_addr[15:6] == `AODR_BLOCK_REGS && aw_addr[1:0] == 2'b00;
	wire        aw_status = aw_addr[15:2] == {`AODR_BLOCK_STATUS, 4'h0} && aw_addr[1:0] == 2'b00;
	wire        ar_regs   = s_axi_araddr[15:6] == `AODR_BLOCK_REGS && s_axi_araddr[1:0] == 2'b00;
	wire        ar_status = s_axi_araddr[15:2] == {`AODR_BLOCK_STATUS, 4'h0}
		&& s_axi_araddr[1:0] == 2'b00;
	wire        commit    = aw_held && w_held && !s_axi_bvalid;
	integer     i;

	always @(posedge clock) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AODR_RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 16'h0000;
			w_byte        <= 8'h00;
			w_lane0       <= 1'b0;
			for (i = 0; i < 16; i = i + 1)
				regs[i] <= reg_reset(i[3:0]); // [R12] [R20]
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_byte       <= s_axi_wdata[7:0];
				w_lane0      <= s_axi_wstrb[0];
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (commit) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_regs || aw_status) ? `AODR_RESP_OKAY : `AODR_RESP_SLVERR;
				if (aw_regs && w_lane0)
					regs[aw_addr[5:2]] <= w_byte & reg_mask(aw_addr[5:2]);
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always @(posedge clock) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `AODR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			if (ar_regs) begin
				s_axi_rdata <= {24'h000000, regs[s_axi_araddr[5:2]]};
				s_axi_rresp <= `AODR_RESP_OKAY;
			end else if (ar_status) begin
				s_axi_rdata <= {24'h000000, status};
				s_axi_rresp <= `AODR_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `AODR_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************************************
	// Decoded configuration
	// ****************************************************************
	wire [7:0]  ctl      = regs[0];
	wire [7:0]  vol      = regs[2];
	wire [7:0]  mode     = regs[3];
	wire [7:0]  nla      = regs[8];
	wire [7:0]  nlb      = regs[9];
	wire [7:0]  nra      = regs[10];
	wire [7:0]  nrb      = regs[11];
	wire [19:0] step_raw = {regs[7], regs[6], regs[5][7:4]}; // [R11]
	wire [3:0]  factor   = regs[5][3:0];
	wire        run      = ctl[`AODR_CTL_SDM_PLAY] | ctl[`AODR_CTL_SER_PLAY];
	wire [1:0]  src_l    = dither_src(nrb[`AODR_CONST_SEL_L], mode[`AODR_MODE_SHAPE_L],
		nla[`AODR_NOISE_EN_FIRST], nla[`AODR_NOISE_EN_SECOND]); // [R1] [R3] [R4] [R7]
	wire [1:0]  src_r    = dither_src(nrb[`AODR_CONST_SEL_R], mode[`AODR_MODE_SHAPE_R],
		nlb[`AODR_NOISE_EN_FIRST], nlb[`AODR_NOISE_EN_SECOND]); // [R2] [R5] [R6] [R8]

	// Control outputs are re-timed so that every output comes from a flip-flop.
	always @(posedge clock) begin
		if (!rstn) begin
			audio_enables <= `AODR_RST_CONTROL;
			center_level  <= `AODR_RST_CENTER;
			rate_step     <= 20'h00000;
			step_tune     <= `AODR_RST_TUNE;
		end else begin
			audio_enables <= ctl; // [R14] [R15]
			center_level  <= regs[1];
			rate_step     <= step_raw;
			step_tune     <= regs[4]; // [R12]
		end
	end

	// ****************************************************************
	// Modulator tick, serial bit clock and rate matcher
	// ****************************************************************
	// The tune value is added to the step, so a step of zero still advances slowly unless the tune is zero.
	reg  [3:0]  div_cnt;
	reg  [18:0] phase;
	reg  [15:0] prev_l;
	reg  [15:0] prev_r;
	reg  [15:0] cur_l;
	reg  [15:0] cur_r;
	wire        tick      = run && div_cnt == factor; // [R13]
	wire [20:0] next_sum  = {2'b00, phase} + {1'b0, step_raw} + {13'h0000, regs[4]}; // [R21]
	wire        wrap      = next_sum[20:`AODR_PHASE_BITS] != 2'b00;
	wire [15:0] in_l      = mode[`AODR_MODE_SWAP] ? sample_right : sample_left; // [R18]
	wire [15:0] in_r      = mode[`AODR_MODE_SWAP] ? sample_left : sample_right;
	wire [16:0] mono_sum  = {in_l[15], in_l} + {in_r[15], in_r};
	wire        take      = sample_ready && sample_valid;

	always @(posedge clock) begin
		if (!rstn) begin
			div_cnt          <= 4'h0;
			serial_bit_clock <= 1'b0;
			phase            <= 19'h00000;
			sample_ready     <= 1'b0;
			prev_l           <= 16'h0000;
			prev_r           <= 16'h0000;
			cur_l            <= 16'h0000;
			cur_r            <= 16'h0000;
		end else begin
			if (!run) begin
				div_cnt          <= 4'h0;
				serial_bit_clock <= 1'b0;
			end else if (tick) begin
				div_cnt          <= 4'h0;
				serial_bit_clock <= ~serial_bit_clock; // [R13]
				phase            <= next_sum[18:0]; // [R21]
			end else begin
				div_cnt <= div_cnt + 4'h1;
			end
			// A new wrap in the same cycle as a take keeps the request raised.
			if (tick && wrap)
				sample_ready <= 1'b1;
			else if (take || !run)
				sample_ready <= 1'b0;
			if (take) begin
				prev_l <= cur_l;
				prev_r <= cur_r;
				if (ctl[`AODR_CTL_MONO]) begin
					cur_l <= mono_sum[16:1]; // [R15]
					cur_r <= mono_sum[16:1];
				end else begin
					cur_l <= in_l;
					cur_r <= in_r;
				end
			end
		end
	end

	// ****************************************************************
	// Dither generators
	// ****************************************************************
	reg  [15:0] lfsr_l1;
	reg  [15:0] lfsr_l2;
	reg  [15:0] lfsr_r1;
	reg  [15:0] lfsr_r2;
	reg  [16:0] last_noise_l;
	reg  [16:0] last_noise_r;
	reg  [15:0] dither_l;
	reg  [15:0] dither_r;
	wire [16:0] noise_l = noise_term(lfsr_l1, nla[4:0], nla[`AODR_NOISE_EN_FIRST])
		+ noise_term(lfsr_l2, nlb[4:0], nla[`AODR_NOISE_EN_SECOND]); // [R7] [R9]
	wire [16:0] noise_r = noise_term(lfsr_r1, nra[4:0], nlb[`AODR_NOISE_EN_FIRST])
		+ noise_term(lfsr_r2, nrb[4:0], nlb[`AODR_NOISE_EN_SECOND]); // [R8] [R10]
	wire [17:0] shaped_l = {noise_l[16], noise_l} - {last_noise_l[16], last_noise_l};
	wire [17:0] shaped_r = {noise_r[16], noise_r} - {last_noise_r[16], last_noise_r};

	always @(posedge clock) begin
		if (!rstn) begin
			lfsr_l1      <= SEED_FIRST;
			lfsr_l2      <= SEED_SECOND;
			lfsr_r1      <= ~SEED_FIRST;
			lfsr_r2      <= ~SEED_SECOND;
			last_noise_l <= 17'h00000;
			last_noise_r <= 17'h00000;
			dither_l     <= 16'h0000;
			dither_r     <= 16'h0000;
		end else if (tick) begin
			lfsr_l1      <= lfsr_next(lfsr_l1);
			lfsr_l2      <= lfsr_next(lfsr_l2);
			lfsr_r1      <= lfsr_next(lfsr_r1);
			lfsr_r2      <= lfsr_next(lfsr_r2);
			last_noise_l <= noise_l;
			last_noise_r <= noise_r;
			// Exactly one source is chosen per channel.
			case (src_l) // [R22]
				`AODR_DSRC_CONST:  dither_l <= {regs[13], regs[12]}; // [R1] [R20]
				`AODR_DSRC_NOISE:  dither_l <= sat16({{31{noise_l[16]}}, noise_l}); // [R3]
				`AODR_DSRC_SHAPED: dither_l <= sat16({{30{shaped_l[17]}}, shaped_l}); // [R4]
				default:           dither_l <= 16'h0000;
			endcase
			case (src_r) // [R22]
				`AODR_DSRC_CONST:  dither_r <= {regs[15], regs[14]}; // [R2] [R20]
				`AODR_DSRC_NOISE:  dither_r <= sat16({{31{noise_r[16]}}, noise_r}); // [R5]
				`AODR_DSRC_SHAPED: dither_r <= sat16({{30{shaped_r[17]}}, shaped_r}); // [R6]
				default:           dither_r <= 16'h0000;
			endcase
		end
	end

	// ****************************************************************
	// Sample path and sigma-delta modulators
	// ****************************************************************
	reg  [18:0] integ_l;
	reg  [18:0] integ_r;
	wire [15:0] ip_l  = interp(prev_l, cur_l, phase[18:11], mode[`AODR_MODE_LINEAR]); // [R17]
	wire [15:0] ip_r  = interp(prev_r, cur_r, phase[18:11], mode[`AODR_MODE_LINEAR]);
	wire [15:0] vo_l  = pwm_scale(vol_apply(ip_l, vol), mode[`AODR_MODE_PWM],
		mode[`AODR_MODE_PWM_NOX2]); // [R16] [R24]
	wire [15:0] vo_r  = pwm_scale(vol_apply(ip_r, vol), mode[`AODR_MODE_PWM],
		mode[`AODR_MODE_PWM_NOX2]);
	wire [15:0] dl    = sat16($signed({{32{vo_l[15]}}, vo_l}) + $signed({{32{dither_l[15]}}, dither_l}));
	wire [15:0] dr    = sat16($signed({{32{vo_r[15]}}, vo_r}) + $signed({{32{dither_r[15]}}, dither_r}));
	wire [15:0] mod_l = nra[`AODR_EXCHANGE] ? dr : dl; // [R19]
	wire [15:0] mod_r = nra[`AODR_EXCHANGE] ? dl : dr;
	// First-order loop: feedback is full scale of the sign of the integrator.
	wire [18:0] fb_l  = integ_l[18] ? 19'h78000 : 19'h07FFF;
	wire [18:0] fb_r  = integ_r[18] ? 19'h78000 : 19'h07FFF;
	wire [18:0] next_integ_l = integ_l + {{3{mod_l[15]}}, mod_l} - fb_l; // [R23]
	wire [18:0] next_integ_r = integ_r + {{3{mod_r[15]}}, mod_r} - fb_r;

	always @(posedge clock) begin
		if (!rstn || !ctl[`AODR_CTL_SDM_PLAY]) begin
			integ_l       <= 19'h00000;
			integ_r       <= 19'h00000;
			sdm_out_left  <= 1'b0;
			sdm_out_right <= 1'b0;
		end else if (tick) begin
			integ_l       <= next_integ_l;
			integ_r       <= next_integ_r;
			sdm_out_left  <= ~next_integ_l[18]; // [R23]
			sdm_out_right <= ~next_integ_r[18];
		end
	end

	always @(posedge clock) begin
		if (!rstn)
			status <= 8'h00;
		else
			status <= {1'b0, src_r, src_l, sdm_out_right, sdm_out_left, sample_ready};
	end

endmodule // aodr_ctrl

// file: shared/aodr_regs.vh
// Register indices, field positions, reset values and constants of the audio output control.
// Assumes a 32-bit AXI4-Lite bus: each byte register sits in lane 0 of word (index * 4).
`ifndef AODR_REGS_VH
`define AODR_REGS_VH

// ****************************************************************
// Register indices and decode blocks
// ****************************************************************
`define AODR_IDX_CONTROL      12'h560
`define AODR_IDX_CENTER       12'h561
`define AODR_IDX_VOLUME       12'h562
`define AODR_IDX_MODE         12'h563
`define AODR_IDX_TUNE         12'h564
`define AODR_IDX_FACTOR       12'h565
`define AODR_IDX_STEP_MID     12'h566
`define AODR_IDX_STEP_HIGH    12'h567
`define AODR_IDX_NOISE_LA     12'h568
`define AODR_IDX_NOISE_LB     12'h569
`define AODR_IDX_NOISE_RA     12'h56A
`define AODR_IDX_NOISE_RB     12'h56B
`define AODR_IDX_CONST_LL     12'h56C
`define AODR_IDX_CONST_LH     12'h56D
`define AODR_IDX_CONST_RL     12'h56E
`define AODR_IDX_CONST_RH     12'h56F
`define AODR_IDX_STATUS       12'h570
`define AODR_BLOCK_REGS       10'h056
`define AODR_BLOCK_STATUS     10'h057

// ****************************************************************
// Reset values
// ****************************************************************
`define AODR_RST_CONTROL      8'h04
`define AODR_RST_CENTER       8'h40
`define AODR_RST_VOLUME       8'h40
`define AODR_RST_MODE         8'h64
`define AODR_RST_TUNE         8'h01
`define AODR_RST_FACTOR       8'h90
`define AODR_RST_STEP_MID     8'hC4
`define AODR_RST_STEP_HIGH    8'h00
`define AODR_RST_NOISE_LA     8'h50
`define AODR_RST_NOISE_LB     8'h40
`define AODR_RST_NOISE_RA     8'h10
`define AODR_RST_NOISE_RB     8'h00
`define AODR_RST_CONST        8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define AODR_CTL_MONO         0
`define AODR_CTL_SER_PLAY     1
`define AODR_CTL_SDM_PLAY     2
`define AODR_CTL_TIMED_PLAY   3
`define AODR_CTL_SER_REC      4
`define AODR_CTL_SER_IFACE    5
`define AODR_CTL_CENTER       6
`define AODR_CTL_HIGHPASS     7
`define AODR_VOL_QUARTER      0
`define AODR_VOL_HALF         1
`define AODR_VOL_MUTE         7
`define AODR_MODE_PWM_NOX2    0
`define AODR_MODE_PWM         1
`define AODR_MODE_LINEAR      2
`define AODR_MODE_SHAPE_L     5
`define AODR_MODE_SHAPE_R     6
`define AODR_MODE_SWAP        7
`define AODR_NOISE_EN_FIRST   6
`define AODR_NOISE_EN_SECOND  5
`define AODR_EXCHANGE         5
`define AODR_CONST_SEL_L      5
`define AODR_CONST_SEL_R      6

// ****************************************************************
// Write masks (reserved bits read as zero) and constants
// ****************************************************************
`define AODR_MASK_ALL         8'hFF
`define AODR_MASK_MODE        8'hE7
`define AODR_MASK_NOISE_A     8'h7F
`define AODR_MASK_NOISE_RA    8'h3F
`define AODR_MASK_NOISE_RB    8'h7F
`define AODR_NOISE_MAX_BITS   5'd16
`define AODR_PHASE_BITS       19
`define AODR_DSRC_NONE        2'd0
`define AODR_DSRC_NOISE       2'd1
`define AODR_DSRC_SHAPED      2'd2
`define AODR_DSRC_CONST       2'd3
`define AODR_RESP_OKAY        2'b00
`define AODR_RESP_SLVERR      2'b10

`endif

// file: verification/aodr_ctrl_properties.sv
// Checker for the audio output control, watching the top module ports only.
// Assumes one clock domain with synchronous active-low reset; bound into aodr_ctrl.
module aodr_ctrl_props (
	input wire logic	clock,
	input wire logic	rstn,
	input wire logic [15:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic [3:0]	s_axi_wstrb,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic	sample_valid,
	input wire logic	sample_ready,
	input wire logic	sdm_out_left,
	input wire logic	sdm_out_right,
	input wire logic	serial_bit_clock,
	input wire logic [7:0]	audio_enables,
	input wire logic [19:0]	rate_step,
	input wire logic [7:0]	step_tune
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire	wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];

	chk_reset_values: assert property ($rose(rstn) |-> (audio_enables == 8'h04
		&& step_tune == 8'h01) ##1 rate_step == 20'h00C49) else $error("reset values wrong");
	chk_control_copy: assert property (wr_go && s_axi_awaddr == 16'h1580 |-> ##3
		{24'h0, audio_enables} == ($past(s_axi_wdata, 3) & 32'h0000_00FF)) else $error("enables");
	chk_tune_copy: assert property (wr_go && s_axi_awaddr == 16'h1590 |-> ##3
		{24'h0, step_tune} == ($past(s_axi_wdata, 3) & 32'h0000_00FF)) else $error("tune");
	chk_bitclk_idle: assert property ((audio_enables[2:1] == 2'b00) [*2] |-> !serial_bit_clock)
		else $error("bit clock runs while idle");
	chk_sdm_idle: assert property (!audio_enables[2] [*2] |-> !sdm_out_left && !sdm_out_right)
		else $error("modulator active while off");
	chk_ready_idle: assert property ((audio_enables[2:1] == 2'b00) [*2] |-> !sample_ready)
		else $error("sample request while idle");
	chk_ready_holds: assert property (sample_ready && !sample_valid && s_axi_awready |=> sample_ready)
		else $error("sample request dropped");
	chk_bitclk_runs: assert property (audio_enables[2] [*2] |-> ##[1:34]
		(serial_bit_clock != $past(serial_bit_clock) || !audio_enables[2])) else $error("bit clock stuck");
endmodule // aodr_ctrl_props

bind aodr_ctrl aodr_ctrl_props u_props (.clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.sample_valid(sample_valid), .sample_ready(sample_ready), .sdm_out_left(sdm_out_left),
	.sdm_out_right(sdm_out_right), .serial_bit_clock(serial_bit_clock),
	.audio_enables(audio_enables), .rate_step(rate_step), .step_tune(step_tune));

// file: verification/aodr_src_model.sv
// Sample fetch side model: offers left and right pairs on a valid and ready handshake.
// Assumes the bench seeds the generator; slow mode stalls at random between pairs.
module aodr_src (
	input wire logic	clock,
	input wire logic	rstn,
	input wire logic	sample_ready,
	input wire logic	slow,
	output logic		sample_valid,
	output logic [15:0]	sample_left,
	output logic [15:0]	sample_right
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Source
	// ****************************************************************
	// Idle data is inverted so a stale pair can never pass for a fresh one.
	always @(posedge clock) begin
		if (!rstn) begin
			sample_valid <= 1'b0;
			sample_left <= 16'h0000;
			sample_right <= 16'h0000;
		end else if (sample_valid && sample_ready) begin
			sample_valid <= 1'b0;
			sample_left <= ~sample_left;
			sample_right <= ~sample_right;
		end else if (!sample_valid && (!slow || $urandom_range(3) == 0)) begin
			sample_valid <= 1'b1;
			sample_left <= 16'($urandom);
			sample_right <= 16'($urandom);
		end
	end
endmodule // aodr_src

// file: verification/tb_top.sv
// Self-checking bench for the audio output control.
// Assumes aodr_ctrl, the source model and the checker are compiled before it.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic		clock = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic		rready = 0, slow = 0;
	logic [15:0]	awaddr = 0, araddr = 0, sl, sr;
	logic [31:0]	wdata = 0, rdata;
	logic		awready, wready, bvalid, arready, rvalid, sv, srdy, sdl, sdr, bclk;
	logic [1:0]	bresp, rresp, r;
	logic [7:0]	aen, tune, d, v, wv[16];
	logic [19:0]	step;
	int		errors = 0, num_checks = 0, cyc = 0, i, j, f, n, takes;
	logic [7:0]	rst_v[16] = '{8'h04, 8'h40, 8'h40, 8'h64, 8'h01, 8'h90, 8'hC4, 8'h00,
		8'h50, 8'h40, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]	msk[16] = '{8'hFF, 8'hFF, 8'hFF, 8'hE7, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h7F, 8'h7F, 8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	always #12.5 clock = ~clock;
	aodr_ctrl DUT (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sample_left(sl), .sample_right(sr), .sample_valid(sv), .sample_ready(srdy),
		.sdm_out_left(sdl), .sdm_out_right(sdr), .serial_bit_clock(bclk), .audio_enables(aen),
		.center_level(), .rate_step(step), .step_tune(tune));
	aodr_src SRC (.clock(clock), .rstn(rstn), .sample_ready(srdy), .slow(slow),
		.sample_valid(sv), .sample_left(sl), .sample_right(sr));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	function automatic logic [1:0] src(input logic c, input logic s, input logic [1:0] e);
		return c ? 2'd3 : (e == 2'd0) ? 2'd0 : s ? 2'd2 : 2'd1;
	endfunction
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] val);
		@(posedge clock);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, val};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
	endtask
	task automatic rd(input logic [11:0] idx);
		@(posedge clock);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		d = rdata[7:0];
		r = rresp;
		rready <= 0;
	endtask
	task automatic toggle_gap;
		logic b;
		b = bclk;
		for (n = 1; n < 100; n++) begin
			@(posedge clock);
			#1;
			if (bclk !== b) break;
		end
	endtask
	always @(posedge clock) if (++cyc == 20000) begin
		errors++;
		summarize();
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		void'($urandom(32'h789ecf26));
		repeat (3) @(posedge clock);
		rstn <= 1;
		for (i = 0; i < 16; i++) begin
			rd(12'h560 + i[11:0]);
			chk("reset", rst_v[i], d);
			v = 8'($urandom);
			wv[i] = v;
			wr(12'h560 + i[11:0], v);
			if (i == 0) #1 chk("enables", v, aen);
			rd(12'h560 + i[11:0]);
			chk("readback", v & msk[i], d);
		end
		chk("step", {wv[7], wv[6], wv[5][7:4]}, step);
		chk("tune", wv[4], tune);
		rd(12'h580);
		chk("unmapped", 2'b10, r);
		for (i = 0; i < 16; i++) begin
			j = 15 - i;
			wr(12'h568, {1'b0, i[0], i[1], 5'd16});
			wr(12'h569, {1'b0, j[0], j[1], 5'd8});
			wr(12'h563, {1'b0, j[2], i[2], 5'd4});
			wr(12'h56B, {1'b0, j[3], i[3], 5'd4});
			rd(12'h570);
			chk("source", {src(j[3], j[2], j[1:0]), src(i[3], i[2], i[1:0])}, d[6:3]);
		end
		f = $urandom_range(15);
		wr(12'h565, {4'h0, f[3:0]});
		wr(12'h560, 8'h04);
		toggle_gap();
		toggle_gap();
		chk("bitclk", f + 1, n);
		wr(12'h565, 8'h00);
		wr(12'h566, 8'h00);
		wr(12'h567, 8'h40);
		wr(12'h564, 8'h00);
		takes = 0;
		repeat (200) @(posedge clock) if (sv && srdy) takes++;
		chk("takes", 1, takes >= 99 && takes <= 101);
		slow <= 1;
		repeat (200) @(posedge clock);
		wr(12'h560, 8'h00);
		repeat (3) @(posedge clock);
		#1 chk("idle", 0, {srdy, bclk, sdl, sdr});
		summarize();
	end
endmodule // tb_top
